// >>> include/sic_pkg.sv
package sic_pkg;

    localparam int unsigned ADDR_W = 8;

    // Byte addresses of the register words
    localparam logic [7:0] OFF_DATA = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_CLEAR = 8'h08;
    localparam logic [7:0] OFF_MODE = 8'h0C;
    localparam logic [7:0] OFF_COMM = 8'h10;
    localparam logic [7:0] OFF_LEVELS = 8'h14;
    localparam logic [7:0] OFF_OES = 8'h18;
    localparam logic [7:0] OFF_START = 8'h1C;
    localparam logic [7:0] OFF_STOP = 8'h20;
    localparam logic [7:0] OFF_RUNNING = 8'h24;
    localparam logic [7:0] OFF_PRESCALE = 8'h28;

    // Field positions
    localparam int unsigned DIV_MSB = 15;
    localparam int unsigned DIV_LSB = 9;
    localparam int unsigned CKS_BIT = 15;
    localparam int unsigned TXE_BIT = 15;
    localparam int unsigned RXE_BIT = 14;
    localparam int unsigned CKO_BIT = 8;
    localparam int unsigned SO_BIT = 0;
    localparam int unsigned OVF_BIT = 0;
    localparam int unsigned ACKERR_BIT = 1;
    localparam int unsigned BFF_BIT = 5;
    localparam int unsigned TSF_BIT = 6;
    localparam int unsigned PRS1_LSB = 4;

    // Reset values
    localparam logic [15:0] MODE_RST = 16'h0020;
    localparam logic [15:0] COMM_RST = 16'h0087;
    localparam logic [15:0] LEVELS_RST = 16'h0101;
    localparam logic [15:0] OES_RST = 16'h0000;
    localparam logic [6:0] DIV_RST = 7'h01;

    // Timing
    localparam int unsigned PCLK_HZ = 50_000_000;
    localparam int unsigned FAST_MODE_HZ = 400_000;
    localparam int unsigned STD_MODE_HZ = 100_000;
    localparam logic [3:0] PRS_MAX = 4'hB;
    localparam logic [3:0] LAST_SLOT = 4'h8;
    localparam logic [6:0] DIV_MIN = 7'h01;

    typedef enum logic [1:0] {PH_IDLE, PH_LOW, PH_HIGH} sic_phase_e;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [31:0] pwdata;
    } sic_apb_req_s;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } sic_apb_rsp_s;

    typedef struct packed {
        logic scl_out;
        logic scl_oe;
        logic sda_out;
        logic sda_oe;
    } sic_pins_s;

endpackage

// >>> rtl/sic_prescaler.sv
module sic_prescaler #(
    parameter int unsigned CNT_W = 11
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [3:0] prs0,
    input wire logic [3:0] prs1,
    input wire logic cks,
    output logic mck_en
);

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic en;
    } sic_pre_s;

    sic_pre_s st_reg;
    sic_pre_s st_next;

    // Codes above the table are clamped rather than left undefined
    function automatic logic [CNT_W-1:0] sic_mask(input logic [3:0] k);
        logic [3:0] kk;
        kk = (k > sic_pkg::PRS_MAX) ? sic_pkg::PRS_MAX : k;
        sic_mask = CNT_W'((1 << kk) - 1);
    endfunction

    always_comb begin
        logic [CNT_W-1:0] m;
        m = cks ? sic_mask(prs1) : sic_mask(prs0);
        st_next = st_reg;
        st_next.cnt = st_reg.cnt + CNT_W'(1);
        st_next.en = ((st_reg.cnt & m) == m);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign mck_en = st_reg.en;

endmodule // sic_prescaler

// >>> rtl/sic_channel.sv
// Function
// - Only a transfer-end event is raised; buffer-empty events never occur.
// - Reception flags only overrun: byte completes while previous unread.
// - Fastest bus clock is operation clock over four; divider at least one.
// - Eight bits in, MSB first, no parity, then one acknowledge slot driven.
// - Data taken uninverted; data line idles high.
// - Hardware updates clock and data output levels during communication.
// - Reception follows address phase; master clocks bytes into receive data.
// - No acknowledge after final byte; stop bit halts channel, then stop.
// - After all bytes, stop condition is made and both lines released.
// - Bus rate is operation clock over divider plus one, over two.
// - Operation clock picked by prescaler register and mode clock-select bit.
// - Prescaler code k gives peripheral clock over two to the k.
// - Writing a read status value to flag clear clears only overrun and ack error; buffer full clears on a data read.
//
// Local design decisions: the register offsets and the APB slave port.
module sic_channel (
    input wire logic pclk,
    input wire logic presetn,
    input wire sic_pkg::sic_apb_req_s apb_req,
    output sic_pkg::sic_apb_rsp_s apb_rsp,
    input wire logic sda_in,
    output sic_pkg::sic_pins_s bus_pins,
    output logic xfer_done
);

    typedef struct packed {
        logic [15:0] mode_config_reg;
        logic [15:0] comm_config_reg;
        logic [15:0] output_level_reg;
        logic [15:0] output_enable_reg;
        logic [3:0] prs0;
        logic [3:0] prs1;
        logic [6:0] divider;
        logic [7:0] tx_byte;
        logic [7:0] rx_byte;
        logic [7:0] shift;
        logic run;
        logic bff;
        logic ovf;
        logic ackerr;
        sic_pkg::sic_phase_e phase;
        logic [3:0] slot;
        logic [6:0] hcnt;
        logic done;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        sic_pkg::sic_pins_s pins;
    } sic_state_s;

    sic_state_s st_reg;
    sic_state_s st_next;
    logic mck_en;
    logic busy;
    logic fire;
    logic wr;
    logic rd_clear;
    logic txe;
    logic rxe;
    logic soe;
    logic [6:0] eff_div;

    sic_prescaler u_prescaler (
        .pclk(pclk),
        .presetn(presetn),
        .prs0(st_reg.prs0),
        .prs1(st_reg.prs1),
        .cks(st_reg.mode_config_reg[sic_pkg::CKS_BIT]),
        .mck_en(mck_en)
    );

    assign busy = (st_reg.phase != sic_pkg::PH_IDLE);
    assign fire = apb_req.psel && apb_req.penable && st_reg.pready;
    assign wr = fire && apb_req.pwrite;
    assign rd_clear = fire && !apb_req.pwrite && (apb_req.paddr == sic_pkg::OFF_DATA);
    assign txe = st_reg.comm_config_reg[sic_pkg::TXE_BIT];
    assign rxe = st_reg.comm_config_reg[sic_pkg::RXE_BIT];
    assign soe = st_reg.output_enable_reg[0];
    // A prohibited zero would give twice the legal top rate; floor it instead
    assign eff_div = (st_reg.divider < sic_pkg::DIV_MIN) ? sic_pkg::DIV_MIN : st_reg.divider;

    function automatic logic sic_hit(input logic [sic_pkg::ADDR_W-1:0] a);
        sic_hit = (a == sic_pkg::OFF_DATA) || (a == sic_pkg::OFF_STATUS) || (a == sic_pkg::OFF_CLEAR)
            || (a == sic_pkg::OFF_MODE) || (a == sic_pkg::OFF_COMM) || (a == sic_pkg::OFF_LEVELS)
            || (a == sic_pkg::OFF_OES) || (a == sic_pkg::OFF_START) || (a == sic_pkg::OFF_STOP)
            || (a == sic_pkg::OFF_RUNNING) || (a == sic_pkg::OFF_PRESCALE);
    endfunction

    // Level for the data line in a given slot; ack slot pulls low only when receiving
    function automatic logic sic_slot_level(input logic [3:0] s, input logic [7:0] b, input logic t,
                                            input logic r);
        if (s < sic_pkg::LAST_SLOT) begin
            sic_slot_level = t ? b[3'(4'h7 - s)] : 1'b1;
        end else begin
            sic_slot_level = (r && !t) ? 1'b0 : 1'b1;
        end
    endfunction

    always_comb begin
        logic ovf_set;
        logic ack_set;
        logic bff_set;
        logic [31:0] rd;
        ovf_set = 1'b0;
        ack_set = 1'b0;
        bff_set = 1'b0;
        rd = '0;
        st_next = st_reg;
        st_next.done = 1'b0;
        st_next.pready = 1'b0;
        st_next.pslverr = 1'b0;

        // Bus engine, stepped by the operation clock enable
        if (mck_en) begin
            case (st_reg.phase)
                sic_pkg::PH_IDLE: begin
                end
                sic_pkg::PH_LOW: begin
                    if (st_reg.hcnt != 7'h00) begin
                        st_next.hcnt = st_reg.hcnt - 7'h01;
                    end else begin
                        st_next.phase = sic_pkg::PH_HIGH;
                        st_next.hcnt = eff_div;
                        st_next.output_level_reg[sic_pkg::CKO_BIT] = 1'b1;
                    end
                end
                sic_pkg::PH_HIGH: begin
                    if (st_reg.hcnt != 7'h00) begin
                        st_next.hcnt = st_reg.hcnt - 7'h01;
                    end else if (st_reg.slot < sic_pkg::LAST_SLOT) begin
                        st_next.shift = {st_reg.shift[6:0], sda_in};
                        st_next.slot = st_reg.slot + 4'h1;
                        st_next.phase = sic_pkg::PH_LOW;
                        st_next.hcnt = eff_div;
                        st_next.output_level_reg[sic_pkg::CKO_BIT] = 1'b0;
                        if (soe) begin
                            st_next.output_level_reg[sic_pkg::SO_BIT] =
                                sic_slot_level(st_reg.slot + 4'h1, st_reg.tx_byte, txe, rxe);
                        end
                    end else begin
                        // Clock held low between bytes; data released for stop or next byte
                        st_next.phase = sic_pkg::PH_IDLE;
                        st_next.output_level_reg[sic_pkg::CKO_BIT] = 1'b0;
                        if (soe) begin
                            st_next.output_level_reg[sic_pkg::SO_BIT] = 1'b1;
                        end
                        st_next.done = 1'b1;
                        if (txe) begin
                            ack_set = sda_in;
                        end else if (rxe) begin
                            st_next.rx_byte = st_reg.shift;
                            bff_set = 1'b1;
                            ovf_set = st_reg.bff && !rd_clear;
                        end
                    end
                end
                default: begin
                    st_next.phase = sic_pkg::PH_IDLE;
                end
            endcase
        end

        // APB: one wait state, answer prepared in the first access cycle
        if (apb_req.psel && apb_req.penable && !st_reg.pready) begin
            st_next.pready = 1'b1;
            st_next.pslverr = !sic_hit(apb_req.paddr);
            case (apb_req.paddr)
                sic_pkg::OFF_DATA: rd = 32'({st_reg.divider, 1'b0, st_reg.rx_byte});
                // Busy bit lets software poll when the done event is not wired up
                sic_pkg::OFF_STATUS: rd = (32'(st_reg.ovf) << sic_pkg::OVF_BIT)
                    | (32'(st_reg.ackerr) << sic_pkg::ACKERR_BIT)
                    | (32'(st_reg.bff) << sic_pkg::BFF_BIT)
                    | (32'(busy) << sic_pkg::TSF_BIT);
                sic_pkg::OFF_MODE: rd = 32'(st_reg.mode_config_reg);
                sic_pkg::OFF_COMM: rd = 32'(st_reg.comm_config_reg);
                sic_pkg::OFF_LEVELS: rd = 32'(st_reg.output_level_reg);
                sic_pkg::OFF_OES: rd = 32'(st_reg.output_enable_reg);
                sic_pkg::OFF_RUNNING: rd = 32'(st_reg.run);
                sic_pkg::OFF_PRESCALE: rd = 32'({st_reg.prs1, st_reg.prs0});
                default: rd = 32'h0000_0000;
            endcase
            st_next.prdata = rd;
        end

        if (wr) begin
            case (apb_req.paddr)
                sic_pkg::OFF_DATA: begin
                    if (!st_reg.run) begin
                        st_next.divider = apb_req.pwdata[sic_pkg::DIV_MSB:sic_pkg::DIV_LSB];
                    end else if (!busy && (txe || rxe)) begin
                        // Write while running starts one byte frame
                        st_next.tx_byte = apb_req.pwdata[7:0];
                        st_next.phase = sic_pkg::PH_LOW;
                        st_next.slot = 4'h0;
                        st_next.hcnt = eff_div;
                        st_next.output_level_reg[sic_pkg::CKO_BIT] = 1'b0;
                        if (soe) begin
                            st_next.output_level_reg[sic_pkg::SO_BIT] =
                                sic_slot_level(4'h0, apb_req.pwdata[7:0], txe, rxe);
                        end
                    end
                end
                sic_pkg::OFF_MODE: begin
                    if (!busy) begin
                        // Interrupt-source bit forced to transfer end
                        st_next.mode_config_reg = apb_req.pwdata[15:0] & ~16'h0001;
                    end
                end
                sic_pkg::OFF_COMM: begin
                    if (busy) begin
                        st_next.comm_config_reg[sic_pkg::TXE_BIT] = apb_req.pwdata[sic_pkg::TXE_BIT];
                        st_next.comm_config_reg[sic_pkg::RXE_BIT] = apb_req.pwdata[sic_pkg::RXE_BIT];
                    end else begin
                        st_next.comm_config_reg = apb_req.pwdata[15:0];
                    end
                end
                sic_pkg::OFF_LEVELS: begin
                    if (!busy) begin
                        st_next.output_level_reg = apb_req.pwdata[15:0] & 16'h0101;
                    end
                end
                sic_pkg::OFF_OES: begin
                    if (!busy) begin
                        st_next.output_enable_reg = apb_req.pwdata[15:0] & 16'h0001;
                    end
                end
                sic_pkg::OFF_START: begin
                    if (apb_req.pwdata[0]) begin
                        st_next.run = 1'b1;
                    end
                end
                sic_pkg::OFF_STOP: begin
                    if (apb_req.pwdata[0]) begin
                        st_next.run = 1'b0;
                        st_next.phase = sic_pkg::PH_IDLE;
                        st_next.done = 1'b0;
                        bff_set = 1'b0;
                        ovf_set = 1'b0;
                        ack_set = 1'b0;
                    end
                end
                sic_pkg::OFF_PRESCALE: begin
                    if (!busy) begin
                        st_next.prs0 = apb_req.pwdata[3:0];
                        st_next.prs1 = apb_req.pwdata[sic_pkg::PRS1_LSB +: 4];
                    end
                end
                default: begin
                end
            endcase
        end

        // Hardware set wins over a clear in the same cycle
        if (wr && (apb_req.paddr == sic_pkg::OFF_CLEAR)) begin
            st_next.ovf = (st_reg.ovf && !apb_req.pwdata[sic_pkg::OVF_BIT]) || ovf_set;
            st_next.ackerr = (st_reg.ackerr && !apb_req.pwdata[sic_pkg::ACKERR_BIT]) || ack_set;
        end else begin
            st_next.ovf = st_reg.ovf || ovf_set;
            st_next.ackerr = st_reg.ackerr || ack_set;
        end
        st_next.bff = bff_set || (st_reg.bff && !rd_clear);

        // Open-drain pins: drive low only, release for high
        st_next.pins.scl_out = 1'b0;
        st_next.pins.sda_out = 1'b0;
        st_next.pins.scl_oe = !st_next.output_level_reg[sic_pkg::CKO_BIT];
        st_next.pins.sda_oe = !st_next.output_level_reg[sic_pkg::SO_BIT];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '0;
            st_reg.mode_config_reg <= sic_pkg::MODE_RST;
            st_reg.comm_config_reg <= sic_pkg::COMM_RST;
            st_reg.output_level_reg <= sic_pkg::LEVELS_RST;
            st_reg.output_enable_reg <= sic_pkg::OES_RST;
            st_reg.divider <= sic_pkg::DIV_RST;
            st_reg.phase <= sic_pkg::PH_IDLE;
        end else begin
            st_reg <= st_next;
        end
    end

    assign apb_rsp.pready = st_reg.pready;
    assign apb_rsp.pslverr = st_reg.pslverr;
    assign apb_rsp.prdata = st_reg.prdata;
    assign bus_pins = st_reg.pins;
    assign xfer_done = st_reg.done;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    apb_wait_a: assert property (apb_req.psel && apb_req.penable && !st_reg.pready |=> st_reg.pready)
        else $error("APB answer not given after one wait state");

    slot_count_a: assert property (st_reg.done |-> $past(st_reg.slot) == 4'h8)
        else $error("Frame ended without nine bit slots");

    ack_drive_a: assert property (st_reg.phase == sic_pkg::PH_HIGH && st_reg.slot == 4'h8 && rxe && !txe && soe
        |-> st_reg.pins.sda_oe)
        else $error("Acknowledge slot not driven low while receiving");

    nack_free_a: assert property (busy && st_reg.slot == 4'h8 && !soe && !$past(soe) && $past(busy)
        |-> $stable(st_reg.pins.sda_oe))
        else $error("Data line changed in acknowledge slot with output disabled");

    overrun_cause_a: assert property ($rose(st_reg.ovf) |-> st_reg.done && $past(st_reg.bff) && $past(rxe))
        else $error("Overrun flagged without unread byte");

    rx_no_ackerr_a: assert property ($rose(st_reg.ackerr) |-> $past(txe))
        else $error("Acknowledge error flagged outside transmission");

    clear_keep_a: assert property (wr && apb_req.paddr == sic_pkg::OFF_CLEAR && !apb_req.pwdata[0] && st_reg.ovf
        |=> st_reg.ovf)
        else $error("Overrun cleared though not named in clear value");

    half_reload_a: assert property ($rose(st_reg.phase == sic_pkg::PH_HIGH)
        |-> $past(st_reg.hcnt) == 7'h00 && $past(mck_en) && st_reg.hcnt == eff_div && st_reg.hcnt >= 7'h01)
        else $error("Half period not reloaded from divider");

    clock_high_a: assert property (st_reg.phase == sic_pkg::PH_HIGH |-> !st_reg.pins.scl_oe)
        else $error("Bus clock driven low in high phase");

    done_release_a: assert property (st_reg.done && $past(soe) |-> !st_reg.pins.sda_oe)
        else $error("Data line still driven after byte");

    stop_halt_a: assert property (wr && apb_req.paddr == sic_pkg::OFF_STOP && apb_req.pwdata[0]
        |=> !st_reg.run && !busy ##1 !st_reg.done)
        else $error("Stop bit did not halt channel");

    rx_done_c: cover property (st_reg.done && rxe && !txe);
    overrun_c: cover property ($rose(st_reg.ovf));
    nack_slot_c: cover property (busy && st_reg.slot == 4'h8 && !soe);
    tx_done_c: cover property (st_reg.done && txe);
    ack_error_c: cover property ($rose(st_reg.ackerr));

endmodule // sic_channel

// >>> verification/sic_slave_model.sv
module sic_slave_model (
    input wire logic presetn,
    input wire logic scl,
    input wire logic sda,
    input wire logic [7:0] tx_byte,
    output logic pull_low,
    output logic ack_seen
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] slot;
    logic [3:0] drive_idx;
    // New bit only while clock low, so no false start or stop appears
    always @(negedge scl or negedge presetn) begin
        if (!presetn) drive_idx <= 4'h0;
        else drive_idx <= slot;
    end
    always @(posedge scl or negedge presetn) begin
        if (!presetn) begin
            slot <= 4'h0;
            ack_seen <= 1'b1;
        end else begin
            if (slot == 4'h8) ack_seen <= sda;
            slot <= (slot == 4'h8) ? 4'h0 : slot + 4'h1;
        end
    end
    // Open drain: only ever pulls low, released in the acknowledge slot
    assign pull_low = (drive_idx < 4'h8) && !tx_byte[3'h7 - drive_idx[2:0]];
endmodule // sic_slave_model

// >>> verification/simple_i2c_master_rx_stop_baud_tb.sv
module simple_i2c_master_rx_stop_baud_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    sic_pkg::sic_apb_req_s apb_req = '0;
    sic_pkg::sic_apb_rsp_s apb_rsp;
    sic_pkg::sic_pins_s bus_pins;
    logic xfer_done;
    logic scl_w;
    logic sda_w;
    logic pull_low;
    logic ack_seen;
    logic [7:0] tx_byte = 8'hFF;
    logic [31:0] rd = '0;
    logic err = 1'b0;
    int fail_count = 0;
    int checked = 0;
    int done_seen = 0;
    int hi_cnt = 0;
    int hi_width = 0;
    logic [7:0] offs [6] = '{sic_pkg::OFF_MODE, sic_pkg::OFF_COMM, sic_pkg::OFF_LEVELS, sic_pkg::OFF_OES,
                             sic_pkg::OFF_RUNNING, sic_pkg::OFF_STATUS};
    logic [31:0] vals [6] = '{32'h20, 32'h87, 32'h101, 32'h0, 32'h0, 32'h0};

    // Pull-ups on both wires
    assign scl_w = !bus_pins.scl_oe;
    assign sda_w = !(bus_pins.sda_oe || pull_low);
    always #10 pclk = !pclk;

    sic_channel i_dut (.pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp), .sda_in(sda_w),
                       .bus_pins(bus_pins), .xfer_done(xfer_done));
    sic_slave_model i_slave (.presetn(presetn), .scl(scl_w), .sda(sda_w), .tx_byte(tx_byte),
                             .pull_low(pull_low), .ack_seen(ack_seen));

    // High width of the last clock pulse, in pclk cycles
    always @(posedge pclk) begin
        if (xfer_done === 1'b1) done_seen <= done_seen + 1;
        if (scl_w) hi_cnt <= hi_cnt + 1;
        else if (hi_cnt != 0) begin
            hi_width <= hi_cnt;
            hi_cnt <= 0;
        end
    end

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
        int n;
        n = 0;
        @(posedge pclk);
        apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: wdata};
        @(posedge pclk);
        apb_req.penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (apb_rsp.pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            fail_count++;
            print_verdict();
        end
        rd = apb_rsp.prdata;
        err = apb_rsp.pslverr;
        apb_req.psel <= 1'b0;
        apb_req.penable <= 1'b0;
    endtask

    task automatic rd_chk(input string what, input logic [7:0] addr, input logic [31:0] exp);
        apb(1'b0, addr, 32'h0);
        check(what, exp, rd);
    endtask

    // Dummy data write starts one received byte
    task automatic recv(input logic [7:0] data);
        int n;
        int d0;
        n = 0;
        d0 = done_seen;
        tx_byte = data;
        apb(1'b1, sic_pkg::OFF_DATA, 32'hFF);
        apb(1'b0, sic_pkg::OFF_STATUS, 32'h0);
        check("busy in frame", 32'h1, {31'h0, rd[sic_pkg::TSF_BIT]});
        while (done_seen == d0 && n < 5000) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 5000) begin
            fail_count++;
            print_verdict();
        end
        @(posedge pclk);
    endtask

    task automatic settle();
        repeat (2) @(posedge pclk);
        #1;
    endtask

    initial begin
        repeat (100000) @(posedge pclk);
        fail_count++;
        print_verdict();
    end

    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        foreach (offs[i]) rd_chk("reset value", offs[i], vals[i]);
        apb(1'b0, 8'h2C, 32'h0);
        check("unmapped error", 32'h1, {31'h0, err});
        check("unmapped data", 32'h0, rd);
        $display("test reset and map done");

        // Both rates stay under 400 kHz at 50 MHz pclk
        apb(1'b1, sic_pkg::OFF_PRESCALE, 32'h64);
        apb(1'b1, sic_pkg::OFF_DATA, 32'h0600);
        apb(1'b1, sic_pkg::OFF_COMM, 32'h4087);
        apb(1'b1, sic_pkg::OFF_OES, 32'h1);
        apb(1'b1, sic_pkg::OFF_START, 32'h1);
        recv(8'hA5);
        check("high width k4 div3", 32'h40, 32'(hi_width));
        check("ack byte A", 32'h0, {31'h0, ack_seen});
        rd_chk("status after A", sic_pkg::OFF_STATUS, 32'h20);
        rd_chk("data A", sic_pkg::OFF_DATA, 32'h06A5);
        check("done pulses A", 32'h1, 32'(done_seen));
        $display("test first byte done");

        apb(1'b1, sic_pkg::OFF_STOP, 32'h1);
        apb(1'b1, sic_pkg::OFF_MODE, 32'h8020);
        apb(1'b1, sic_pkg::OFF_DATA, 32'h0200);
        apb(1'b1, sic_pkg::OFF_START, 32'h1);
        recv(8'h5A);
        check("high width k6 div1", 32'h80, 32'(hi_width));
        check("ack byte B", 32'h0, {31'h0, ack_seen});
        $display("test clock select done");

        // Last byte: output enable off leaves the acknowledge slot released
        apb(1'b1, sic_pkg::OFF_OES, 32'h0);
        recv(8'h3C);
        check("nack last byte", 32'h1, {31'h0, ack_seen});
        rd_chk("status overrun", sic_pkg::OFF_STATUS, 32'h21);
        apb(1'b1, sic_pkg::OFF_CLEAR, rd);
        rd_chk("status cleared", sic_pkg::OFF_STATUS, 32'h20);
        apb(1'b0, sic_pkg::OFF_DATA, 32'h0);
        rd_chk("buffer emptied", sic_pkg::OFF_STATUS, 32'h0);
        $display("test overrun and nack done");

        tx_byte = 8'hFF;
        apb(1'b1, sic_pkg::OFF_STOP, 32'h1);
        rd_chk("running after stop", sic_pkg::OFF_RUNNING, 32'h0);
        apb(1'b1, sic_pkg::OFF_OES, 32'h1);
        apb(1'b1, sic_pkg::OFF_LEVELS, 32'h0100);
        settle();
        check("stop scl high", 32'h1, {31'h0, scl_w});
        check("stop sda low", 32'h0, {31'h0, sda_w});
        apb(1'b1, sic_pkg::OFF_LEVELS, 32'h0101);
        settle();
        check("released sda", 32'h1, {31'h0, sda_w});
        check("released scl", 32'h1, {31'h0, scl_w});
        check("done pulses total", 32'h3, 32'(done_seen));
        $display("test stop condition done");

        // Transmit join: slave stays released, so the ack slot reads high
        apb(1'b1, sic_pkg::OFF_COMM, 32'h8087);
        apb(1'b1, sic_pkg::OFF_START, 32'h1);
        recv(8'hFF);
        check("nack in transmit", 32'h1, {31'h0, ack_seen});
        rd_chk("status ack error", sic_pkg::OFF_STATUS, 32'h2);
        apb(1'b1, sic_pkg::OFF_CLEAR, rd);
        rd_chk("ack error cleared", sic_pkg::OFF_STATUS, 32'h0);
        check("done pulses all", 32'h4, 32'(done_seen));
        $display("test transmit nack done");
        print_verdict();
    end
endmodule // simple_i2c_master_rx_stop_baud_tb
